// >>> core/selector_regs.svh
// Offsets, reset values and timing counts of the supply selector
`ifndef SELECTOR_REGS_SVH
`define SELECTOR_REGS_SVH
`define CLK_HZ 40000000
`define VALID_TIME_MS 256
`define VALID_CYCLES ((`CLK_HZ / 1000) * `VALID_TIME_MS)
`define SOFTSTART_TIME_MS 32
`define SOFTSTART_CYCLES ((`CLK_HZ / 1000) * `SOFTSTART_TIME_MS)
`define OFF_CONFIRM_CYCLES 4
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_TIMER_BASE 12'h008
`define CTRL_RESET 32'h0000_0001
`define CTRL_ENABLE_BIT 0
`define CTRL_FORCE_SS_BIT 1
`endif

// >>> core/selector_pkg.sv
// Types shared by the supply selector blocks
package selector_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ON = 4'b0010,
    ST_OFFWAIT = 4'b0100,
    ST_SHUT = 4'b1000
  } sel_state_t;
  typedef enum logic [1:0] {
    RAIL_OUTPUT = 2'd0,
    RAIL_INPUT = 2'd1,
    RAIL_DIODE_OR = 2'd2
  } rail_src_t;
  typedef struct packed {
    logic in_window;
    logic gate_off;
  } chan_sense_t;
  typedef struct packed {
    logic [31:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : selector_pkg

// >>> core/input_validator.sv
// Per-input window qualification timer
`timescale 1ns/1ps
`include "selector_regs.svh"
module input_validator #(
  parameter int unsigned VALID_CYCLES = `VALID_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic shutdown,
  input wire logic in_window,
  output logic valid,
  output logic [31:0] count
);
  logic [31:0] cnt_q;
  logic valid_q;

  initial begin
    if (VALID_CYCLES < 1) begin
      $error("VALID_CYCLES must be at least one");
    end
  end

  // Counter restarts on any excursion; shutdown clears it
  always_ff @(posedge clk_sys) begin
    if (!nrst || shutdown || !in_window) begin
      cnt_q <= 32'h0;
      valid_q <= 1'b0;
    end else if (cnt_q >= VALID_CYCLES - 1) begin
      valid_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign valid = valid_q;
  assign count = cnt_q;
endmodule : input_validator

// >>> core/soft_start_timer.sv
// Soft-start window timer for the common output ramp
`timescale 1ns/1ps
`include "selector_regs.svh"
module soft_start_timer #(
  parameter int unsigned SS_CYCLES = `SOFTSTART_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rearm,
  input wire logic start,
  input wire logic chan_off_evt,
  output logic armed,
  output logic active
);
  logic armed_q;
  logic active_q;
  logic [31:0] cnt_q;

  initial begin
    if (SS_CYCLES < 1) begin
      $error("SS_CYCLES must be at least one");
    end
  end

  // Armed until the first connection; active until disconnect or timeout
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      armed_q <= 1'b1;
      active_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (rearm) begin
      armed_q <= 1'b1;
      active_q <= 1'b0;
      cnt_q <= 32'h0;
    end else if (active_q) begin
      if (chan_off_evt || cnt_q >= SS_CYCLES - 1) begin
        active_q <= 1'b0;
      end
      cnt_q <= cnt_q + 32'h1;
    end else if (armed_q && start) begin
      armed_q <= 1'b0;
      active_q <= 1'b1;
      cnt_q <= 32'h0;
    end
  end

  assign armed = armed_q;
  assign active = active_q;
endmodule : soft_start_timer

// >>> core/supply_selector.sv
// Prioritized three-input supply selector control with APB registers
`timescale 1ns/1ps
`include "selector_regs.svh"
module supply_selector
  import selector_pkg::*;
#(
  parameter int unsigned N_IN = 3,
  parameter int unsigned VALID_CYCLES = `VALID_CYCLES,
  parameter int unsigned SS_CYCLES = `SOFTSTART_CYCLES,
  parameter int unsigned OFF_CYCLES = `OFF_CONFIRM_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic shutdown_n,
  input wire logic enable,
  input wire logic [2:0] in_window,
  input wire logic [2:0] gate_off,
  input wire logic output_above_rail,
  input wire logic output_sagged,
  output logic [2:0] gate_on,
  output logic soft_start,
  output logic input1_good_n,
  output logic input2_good_n,
  output logic input3_good_n,
  output logic cascade_n,
  output logic [1:0] internal_regulator_rail,
  output logic [1:0] rail_input_sel,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  initial begin
    if (N_IN != 3 || OFF_CYCLES < 1 || OFF_CYCLES > 255) begin
      $error("Unsupported selector parameters");
    end
  end

  // ---------------------------------------------------------------
  // Shutdown and comparator gating
  // ---------------------------------------------------------------
  logic shut;
  logic shut_q;
  logic [2:0] win_gated;
  logic [2:0] valid;
  logic [31:0] tcount [3];
  chan_sense_t [2:0] sense;

  assign shut = !shutdown_n || !nrst;
  // Comparators are disabled in shutdown so no window is seen
  assign win_gated = shut ? 3'b000 : in_window;

  // Track shutdown to find its release edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      shut_q <= 1'b1;
    end else begin
      shut_q <= !shutdown_n;
    end
  end

  // ---------------------------------------------------------------
  // Validators, one per input
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_val
      assign sense[gi].in_window = win_gated[gi];
      assign sense[gi].gate_off = gate_off[gi];
      // Enable is not an input here, so enable low keeps timing
      input_validator #(
        .VALID_CYCLES(VALID_CYCLES)
      ) u_val (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .shutdown(shut),
        .in_window(sense[gi].in_window),
        .valid(valid[gi]),
        .count(tcount[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Register block
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic sw_enable;
  logic force_ss;
  assign sw_enable = ctrl_q[`CTRL_ENABLE_BIT];
  assign force_ss = ctrl_q[`CTRL_FORCE_SS_BIT];

  // ---------------------------------------------------------------
  // Priority pick and channel sequencer
  // ---------------------------------------------------------------
  logic run;
  logic [1:0] pick;
  logic pick_ok;
  sel_state_t state_q;
  logic [1:0] cur_q;
  logic [7:0] off_cnt_q;
  logic [2:0] gate_q;
  logic cas_q;
  logic chan_off_evt;

  // Enable gates both the pin and the software copy
  assign run = enable && sw_enable && !shut;

  // Highest priority valid input: index 0 first
  always_comb begin
    pick = 2'd0;
    pick_ok = 1'b1;
    if (valid[0]) begin
      pick = 2'd0;
    end else if (valid[1]) begin
      pick = 2'd1;
    end else if (valid[2]) begin
      pick = 2'd2;
    end else begin
      pick_ok = 1'b0;
    end
  end

  // Channel sequencer with break-before-make
  always_ff @(posedge clk_sys) begin
    if (!nrst || shut) begin
      state_q <= ST_SHUT;
      gate_q <= 3'b000;
      cur_q <= 2'd0;
      off_cnt_q <= 8'h0;
      cas_q <= 1'b1;
    end else begin
      case (state_q)
        ST_SHUT, ST_IDLE: begin
          off_cnt_q <= 8'h0;
          if (run && pick_ok) begin
            // Turn-on and cascade pull-down in one step
            gate_q <= 3'b001 << pick;
            cur_q <= pick;
            cas_q <= 1'b0;
            state_q <= ST_ON;
          end else begin
            gate_q <= 3'b000;
            // Disabled with a valid input: hold the slave off too
            cas_q <= run || !pick_ok;
            state_q <= ST_IDLE;
          end
        end
        ST_ON: begin
          // Lost input (undervoltage included) or better one: go off
          if (!run || !valid[cur_q] || pick != cur_q) begin
            gate_q <= 3'b000;
            off_cnt_q <= 8'h0;
            state_q <= ST_OFFWAIT;
          end
        end
        ST_OFFWAIT: begin
          // Wait until every gate reports off before anything else
          if (gate_off == 3'b111 && off_cnt_q >= 8'(OFF_CYCLES - 1)) begin
            if (run && pick_ok) begin
              gate_q <= 3'b001 << pick;
              cur_q <= pick;
              cas_q <= 1'b0;
              state_q <= ST_ON;
            end else begin
              // All channels confirmed off; release cascade unless an input is still valid
              cas_q <= pick_ok ? cas_q : 1'b1;
              state_q <= ST_IDLE;
            end
          end else if (off_cnt_q != 8'hff) begin
            off_cnt_q <= off_cnt_q + 8'h1;
          end
        end
        default: begin
          gate_q <= 3'b000;
          cas_q <= 1'b1;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Enable low keeps cascade low while a valid input stays qualified,
  // so the slave also disconnects
  assign cascade_n = cas_q;
  assign gate_on = gate_q;
  assign chan_off_evt = (state_q == ST_ON) && (gate_q != 3'b000) &&
                        (!run || !valid[cur_q] || pick != cur_q);

  // ---------------------------------------------------------------
  // Soft-start
  // ---------------------------------------------------------------
  logic ss_rearm;
  logic ss_start;
  // Rearm on shutdown release, output sag or software soft-start request
  assign ss_rearm = (shut_q && shutdown_n) || output_sagged || force_ss;
  // The first connection from any input ramps the output
  assign ss_start = (state_q != ST_ON) && run && pick_ok &&
                    (state_q == ST_IDLE || state_q == ST_SHUT ||
                     gate_off == 3'b111);

  soft_start_timer #(
    .SS_CYCLES(SS_CYCLES)
  ) u_ss (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .rearm(ss_rearm),
    .start(ss_start),
    .chan_off_evt(chan_off_evt),
    .armed(),
    .active(soft_start)
  );

  // ---------------------------------------------------------------
  // Good flags and internal rail source
  // ---------------------------------------------------------------
  // Flags read invalid in shutdown since validators clear
  assign input1_good_n = !valid[0];
  assign input2_good_n = !valid[1];
  assign input3_good_n = !valid[2];

  // Rail source: output first, then valid input, else diode-OR
  always_comb begin
    rail_input_sel = pick;
    if (output_above_rail) begin
      internal_regulator_rail = RAIL_OUTPUT;
    end else if (pick_ok) begin
      internal_regulator_rail = RAIL_INPUT;
    end else begin
      internal_regulator_rail = RAIL_DIODE_OR;
    end
  end

  // ---------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = (paddr[11:0] == `REG_CTRL) || (paddr[11:0] == `REG_STATUS) ||
               (paddr[11:0] >= `REG_TIMER_BASE &&
                paddr[11:0] <= `REG_TIMER_BASE + 12'h008 &&
                paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = acc && (!hit || (pwrite && paddr[11:0] != `REG_CTRL));

  // Control register: software enable and soft-start request
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (acc && pwrite && paddr[11:0] == `REG_CTRL) begin
      ctrl_q <= {30'h0, pwdata[1:0]};
    end else begin
      ctrl_q[`CTRL_FORCE_SS_BIT] <= 1'b0; // Self-clearing request
    end
  end

  // Read data mux, registered for a clean output
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr[11:0])
        `REG_CTRL: prdata <= ctrl_q;
        `REG_STATUS: prdata <= {16'h0, 4'(state_q), 2'(internal_regulator_rail),
                                soft_start, cascade_n, 1'b0, gate_q,
                                1'b0, valid};
        `REG_TIMER_BASE: prdata <= tcount[0];
        12'h00c: prdata <= tcount[1];
        12'h010: prdata <= tcount[2];
        default: prdata <= 32'h0;
      endcase
    end
  end
endmodule : supply_selector

// >>> verification/selector_assertions.sv
// Port checker for the supply selector
`timescale 1ns/1ps
module selector_checker
  import selector_pkg::*;
#(
  parameter int unsigned SS_CYCLES = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic shutdown_n,
  input wire logic enable,
  input wire logic [2:0] gate_on,
  input wire logic soft_start,
  input wire logic input1_good_n,
  input wire logic input2_good_n,
  input wire logic input3_good_n,
  input wire logic cascade_n,
  input wire logic output_above_rail,
  input wire logic [1:0] internal_regulator_rail
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [2:0] bad;
  logic [31:0] ss_q;
  assign bad = {input3_good_n, input2_good_n, input1_good_n};
  // Ramp length in cycles; a counter avoids a long repetition
  always_ff @(posedge clk_sys) begin
    if (!nrst || !soft_start) begin
      ss_q <= '0;
    end else begin
      ss_q <= ss_q + 32'd1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_one_channel: assert property ($onehot0(gate_on))
    else $error("two channels on");
  a_shutdown_n_off: assert property (!shutdown_n |=> gate_on == 3'b000 && cascade_n)
    else $error("shutdown left a channel on");
  a_shutdown_n_flags: assert property (!shutdown_n |=> bad == 3'b111)
    else $error("good flag low in shutdown");
  a_en_off: assert property (!enable |=> gate_on == 3'b000)
    else $error("channel on while disabled");
  a_connect_cas: assert property ($rose(|gate_on) |-> !cascade_n)
    else $error("cascade not low at connect");
  a_cas_release: assert property ($rose(cascade_n) && $past(shutdown_n) |-> $past(gate_on) == 3'b000)
    else $error("cascade released with channel on");
  a_lost_off: assert property (|(gate_on & bad) |=> gate_on == 3'b000)
    else $error("invalid input kept on");
  a_rail_out: assert property (output_above_rail |-> internal_regulator_rail == RAIL_OUTPUT)
    else $error("rail not from output");
  a_rail_diode: assert property (!output_above_rail && &bad |-> internal_regulator_rail == RAIL_DIODE_OR)
    else $error("rail not from diode-or");
  a_ss_bound: assert property (ss_q <= SS_CYCLES + 1)
    else $error("ramp too long");
  a_ss_disc: assert property ($fell(|gate_on) |-> ##[0:1] !soft_start)
    else $error("ramp kept after disconnect");
  c_first: cover property ($rose(gate_on[0]));
  c_release: cover property ($rose(cascade_n));
  c_ramp_end: cover property ($fell(soft_start));
endmodule : selector_checker
bind supply_selector selector_checker #(.SS_CYCLES(SS_CYCLES)) u_selector_checker (
  .clk_sys(clk_sys), .nrst(nrst), .shutdown_n(shutdown_n), .enable(enable),
  .gate_on(gate_on), .soft_start(soft_start), .input1_good_n(input1_good_n),
  .input2_good_n(input2_good_n), .input3_good_n(input3_good_n),
  .cascade_n(cascade_n), .output_above_rail(output_above_rail),
  .internal_regulator_rail(internal_regulator_rail));

// >>> verification/supply_model.sv
// Far side: input supplies, switch feedback and a cascaded lower unit
`timescale 1ns/1ps
module supply_model (
  input wire logic clk_sys,
  input wire logic [2:0] window_req,
  input wire logic [2:0] gate_on,
  input wire logic cascade_n,
  output logic [2:0] in_window,
  output logic [2:0] gate_off,
  output logic slave_on
);
  // ----------------------------------------
  // Switch and cascade behaviour
  // ----------------------------------------
  logic [2:0] off_q;
  // The stimulus never raises the third input: it stays grounded
  assign in_window = window_req;
  // Gates need two cycles to discharge, so the off check is not free
  always_ff @(posedge clk_sys) begin
    off_q <= ~gate_on;
    gate_off <= off_q & ~gate_on;
  end
  // Lower unit always holds a valid input; it runs only when enabled
  always_ff @(posedge clk_sys) begin
    slave_on <= cascade_n;
  end
endmodule : supply_model

// >>> verification/tb_top.sv
// Self-checking bench for the supply selector
`timescale 1ns/1ps
`include "selector_regs.svh"
module tb_top;
  import selector_pkg::*;
  // ----------------------------------------
  // Signals, instances, common tasks
  // ----------------------------------------
  localparam int unsigned VC = 16;
  logic clk_sys = 0, nrst = 0, shutdown_n = 1, enable = 1, above = 0;
  logic psel = 0, penable = 0, pwrite = 0, err;
  logic [2:0] win = 0, in_window, gate_off, gate_on;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic soft_start, g1, g2, g3, cascade_n, pready, pslverr, slave_on;
  logic [1:0] rail;
  int error_cnt = 0, tests_run = 0;
  supply_selector #(.VALID_CYCLES(VC), .SS_CYCLES(32)) u_supply_selector (
    .clk_sys(clk_sys), .nrst(nrst), .shutdown_n(shutdown_n), .enable(enable),
    .in_window(in_window), .gate_off(gate_off), .output_above_rail(above),
    .output_sagged(1'b0), .gate_on(gate_on), .soft_start(soft_start),
    .input1_good_n(g1), .input2_good_n(g2), .input3_good_n(g3),
    .cascade_n(cascade_n), .internal_regulator_rail(rail), .rail_input_sel(),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  supply_model u_supply_model (.clk_sys(clk_sys), .window_req(win),
    .gate_on(gate_on), .cascade_n(cascade_n), .in_window(in_window),
    .gate_off(gate_off), .slave_on(slave_on));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Bounded wait, checked on the falling edge so outputs have settled
  task automatic wait_gate(logic [2:0] exp);
    @(negedge clk_sys);
    for (int i = 0; i < 200 && gate_on !== exp; i++) @(negedge clk_sys);
  endtask : wait_gate
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_validate();
    cyc(1);
    win <= 3'b010;
    cyc(VC - 2);
    @(negedge clk_sys);
    chk(g2, 1'b1);
    wait_gate(3'b010);
    chk(gate_on, 3'b010);
    chk({cascade_n, soft_start}, 2'b01);
    chk(rail, RAIL_INPUT);
  endtask : t_validate
  // A one-cycle dip restarts the timer of the higher input
  task automatic t_priority();
    cyc(1);
    win <= 3'b011;
    cyc(VC / 2);
    win <= 3'b010;
    cyc(1);
    win <= 3'b011;
    cyc(VC - 2);
    @(negedge clk_sys);
    chk({g1, gate_on}, 4'b1010);
    wait_gate(3'b001);
    chk(gate_on, 3'b001);
  endtask : t_priority
  task automatic t_loss();
    cyc(1);
    win <= 3'b010;
    wait_gate(3'b010);
    chk({g1, gate_on}, 4'b1010);
  endtask : t_loss
  // Timers keep running while disabled, so reconnect is quick
  task automatic t_enable();
    cyc(1);
    enable <= 0;
    cyc(VC + 4);
    @(negedge clk_sys);
    chk({gate_on, cascade_n, slave_on, g2}, 6'b000000);
    cyc(1);
    enable <= 1;
    cyc(VC / 2);
    @(negedge clk_sys);
    chk(gate_on, 3'b010);
  endtask : t_enable
  task automatic t_regs();
    apb(0, `REG_CTRL, 0);
    chk(rd, `CTRL_RESET);
    chk(err, 1'b0);
    apb(1, `REG_CTRL, 0);
    wait_gate(3'b000);
    chk(gate_on, 3'b000);
    apb(1, `REG_CTRL, 1);
    apb(0, 32'h0000_0ff0, 0);
    chk(err, 1'b1);
    apb(1, `REG_STATUS, 32'hffff_ffff);
    chk(err, 1'b1);
    wait_gate(3'b010);
    chk(gate_on, 3'b010);
  endtask : t_regs
  task automatic t_all_lost();
    cyc(1);
    win <= 3'b000;
    @(negedge clk_sys);
    for (int i = 0; i < 50 && cascade_n !== 1'b1; i++) @(negedge clk_sys);
    chk({cascade_n, gate_on, gate_off}, 7'b1000111);
    chk(rail, RAIL_DIODE_OR);
    cyc(1);
    above <= 1;
    @(negedge clk_sys);
    chk({rail, slave_on}, {RAIL_OUTPUT, 1'b1});
    above <= 0;
  endtask : t_all_lost
  task automatic t_shutdown();
    cyc(1);
    win <= 3'b001;
    wait_gate(3'b001);
    cyc(1);
    shutdown_n <= 0;
    cyc(2);
    @(negedge clk_sys);
    chk({gate_on, cascade_n, g1, g2, g3}, 7'b0001111);
    cyc(1);
    shutdown_n <= 1;
    cyc(VC - 2);
    @(negedge clk_sys);
    chk(gate_on, 3'b000);
    wait_gate(3'b001);
    chk({gate_on, soft_start}, 4'b0011);
  endtask : t_shutdown
  initial begin
    cyc(10);
    nrst <= 1;
    t_validate();
    t_priority();
    t_loss();
    t_enable();
    t_regs();
    t_all_lost();
    t_shutdown();
    tally_and_finish();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #(25 * 20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule : tb_top
